// ---- hw/rtab_pkg.sv ----
// Function
// - no bus access while main supply is below reset threshold, any mode
// - both selects zero: standard switchover, bus allowed down to reset threshold
// - bus-in-backup 0, switch 1: switch below backup; bus only while main and backup both above reset
// - bus-in-backup 1, switch 0: same as both-zero setting
// - both ones: switch below backup; bus only while main above max(reset, backup)
// - a field with its enable clear never blocks a match
// - alarm raises events only while alarm0 enable bit 5 is set
// - clock reaching the enabled fields sets the alarm0 status flag
// - mode select 0 gives a single-event interrupt per match
// - mode select 1 gives a repeating pulse at each recurrence of the match
// - after power-up the switchover mode defaults to legacy
// - standard mode on backup disables everything except timekeeping
package rtab_pkg;
    localparam logic [3:0] ADDR_ALARM_SEC = 4'h0;
    localparam logic [3:0] ADDR_ALARM_MIN = 4'h1;
    localparam logic [3:0] ADDR_ALARM_HR = 4'h2;
    localparam logic [3:0] ADDR_ALARM_DATE = 4'h3;
    localparam logic [3:0] ADDR_ALARM_MON = 4'h4;
    localparam logic [3:0] ADDR_ALARM_WDAY = 4'h5;
    localparam logic [3:0] ADDR_INT_CTRL = 4'h6;
    localparam logic [3:0] ADDR_BACKUP_CTRL = 4'h7;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h9;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hA;
    localparam logic [3:0] ADDR_GATE_STATUS = 4'hB;
    localparam int FIELD_EN_BIT = 7;
    localparam int NUM_FIELDS = 6;
    localparam int INT_MODE_BIT = 7;
    localparam int ALARM0_EN_BIT = 5;
    localparam int BSW_SEL_BIT = 0;
    localparam int SERIAL_BUS_IN_BACKUP_SELECT_SEL_BIT = 1;
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_GATE_BIT = 1;
    localparam logic [7:0] RST_FIELD = 8'h00;
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    // legacy switchover (battery switch select 1), bus in backup 0
    localparam logic [7:0] RST_BACKUP_CTRL = 8'h01;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam int PULSE_NS = 250;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- hw/rtab_sync2.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtab_sync2 (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic meta;
    logic next_meta;
    logic next_dout;

    always_comb
    begin
        next_meta = din;
        next_dout = meta;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

// ---- hw/rtab_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtab_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // analog comparators: main above reset threshold, above trip, above backup,
    // backup above reset threshold
    input wire logic vdd_above_reset,
    input wire logic vdd_above_trip,
    input wire logic vdd_above_backup,
    input wire logic backup_above_reset,
    // serial bus activity, high from start to stop condition
    input wire logic bus_busy,
    // running clock, BCD, with one-cycle update strobe
    input wire logic [7:0] clk_seconds,
    input wire logic [7:0] clk_minutes,
    input wire logic [7:0] clk_hours,
    input wire logic [7:0] clk_date,
    input wire logic [7:0] clk_month,
    input wire logic [7:0] clk_weekday,
    input wire logic time_update,
    // outputs
    output logic bus_enable,
    output logic on_backup,
    output logic functions_enable,
    output logic alarm0_flag,
    output logic alarm_irq_n,
    output logic irq
);
    logic [7:0] alarm_field [rtab_pkg::NUM_FIELDS];
    logic [7:0] next_alarm_field [rtab_pkg::NUM_FIELDS];
    logic [7:0] int_ctrl;
    logic [7:0] next_int_ctrl;
    logic [7:0] backup_ctrl;
    logic [7:0] next_backup_ctrl;
    logic [1:0] irq_status;
    logic [1:0] next_irq_status;
    logic [1:0] irq_enable;
    logic [1:0] next_irq_enable;
    logic [7:0] next_reg_rdata;
    logic next_irq;

    logic s_above_reset;
    logic s_above_trip;
    logic s_above_backup;
    logic s_bat_above_reset;

    logic next_bus_enable;
    logic next_on_backup;
    logic next_functions_enable;
    logic gate_target;
    logic backup_target;

    logic [7:0] time_now [rtab_pkg::NUM_FIELDS];
    logic [rtab_pkg::NUM_FIELDS-1:0] field_ok;
    logic match_now;
    logic match_prev;
    logic next_match_prev;
    logic alarm_event;
    logic next_alarm0_flag;
    logic [7:0] pulse_cnt;
    logic [7:0] next_pulse_cnt;
    logic next_alarm_irq_n;
    logic alarm_pulse_mode;
    logic alarm_armed;
    logic gate_change;
    logic bsw_sel;
    logic serial_bus_in_backup_select_sel;
    logic status_rd;

    // running time in the same order as the alarm field registers
    assign time_now[0] = clk_seconds;
    assign time_now[1] = clk_minutes;
    assign time_now[2] = clk_hours;
    assign time_now[3] = clk_date;
    assign time_now[4] = clk_month;
    assign time_now[5] = clk_weekday;

    // comparators are asynchronous to sys_clk, so two flops before any decision
    rtab_sync2 u_sync_reset (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din(vdd_above_reset),
        .dout(s_above_reset)
    );
    rtab_sync2 u_sync_trip (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din(vdd_above_trip),
        .dout(s_above_trip)
    );
    rtab_sync2 u_sync_backup (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din(vdd_above_backup),
        .dout(s_above_backup)
    );
    rtab_sync2 u_sync_bat (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din(backup_above_reset),
        .dout(s_bat_above_reset)
    );

    assign bsw_sel = backup_ctrl[rtab_pkg::BSW_SEL_BIT];
    assign serial_bus_in_backup_select_sel = backup_ctrl[rtab_pkg::SERIAL_BUS_IN_BACKUP_SELECT_SEL_BIT];
    assign alarm_pulse_mode = int_ctrl[rtab_pkg::INT_MODE_BIT];

    // supply source and bus gate targets per mode
    always_comb
    begin
        backup_target = 1'b0;
        gate_target = 1'b0;
        if (bsw_sel)
        begin
            backup_target = !s_above_backup;
            if (serial_bus_in_backup_select_sel)
                gate_target = s_above_reset && s_above_backup;
            else
                gate_target = s_above_reset && s_bat_above_reset;
        end
        else
        begin
            // standard switchover at the trip point, for either bus-in-backup value
            backup_target = !s_above_trip;
            gate_target = s_above_reset;
        end
        if (!s_above_reset)
            gate_target = 1'b0;
    end

    // gate is frozen while a transfer runs, except the reset cut-off which always wins
    always_comb
    begin
        next_on_backup = backup_target;
        next_bus_enable = bus_enable;
        if (!s_above_reset)
            next_bus_enable = 1'b0;
        else if (!bus_busy)
            next_bus_enable = gate_target;
        // standard mode on backup keeps only timekeeping alive
        next_functions_enable = !(backup_target && !bsw_sel);
    end

    // a gate edge is latched in status so software learns a transfer was refused
    assign gate_change = (bus_enable != next_bus_enable);

    // alarm comparison
    genvar gi;
    generate
        for (gi = 0; gi < rtab_pkg::NUM_FIELDS; gi++)
        begin : g_field
            assign field_ok[gi] = !alarm_field[gi][rtab_pkg::FIELD_EN_BIT] ||
                (alarm_field[gi][6:0] == time_now[gi][6:0]);
        end
    endgenerate

    assign match_now = &field_ok;
    // rising match at a clock update only, so one event per qualifying update
    // alarms stay quiet while only timekeeping is powered
    assign alarm_armed = int_ctrl[rtab_pkg::ALARM0_EN_BIT] && functions_enable;
    assign alarm_event = time_update && match_now && !match_prev && alarm_armed;
    assign status_rd = reg_rd && (reg_addr == rtab_pkg::ADDR_IRQ_STATUS);

    always_comb
    begin
        next_match_prev = match_prev;
        if (time_update)
            next_match_prev = match_now;
        next_alarm0_flag = alarm0_flag;
        if (status_rd)
            next_alarm0_flag = 1'b0;
        if (alarm_event)
            next_alarm0_flag = 1'b1;
        next_pulse_cnt = pulse_cnt;
        next_alarm_irq_n = alarm_irq_n;
        if (alarm_pulse_mode)
        begin
            // a new event restarts the count, so an event during a pulse stretches it into one longer pulse
            // pulsed mode: fixed low pulse per match, repeats each recurrence
            if (alarm_event)
                next_pulse_cnt = 8'(rtab_pkg::PULSE_CYCLES);
            else if (pulse_cnt != 8'h00)
                next_pulse_cnt = pulse_cnt - 8'h01;
            next_alarm_irq_n = !(alarm_event || pulse_cnt > 8'h01);
        end
        else
        begin
            // single event: held low until software reads status
            next_pulse_cnt = 8'h00;
            next_alarm_irq_n = !next_alarm0_flag;
        end
    end

    // register file
    always_comb
    begin
        for (int i = 0; i < rtab_pkg::NUM_FIELDS; i++)
            next_alarm_field[i] = alarm_field[i];
        next_int_ctrl = int_ctrl;
        next_backup_ctrl = backup_ctrl;
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;
        if (reg_wr)
        begin
            case (reg_addr)
                rtab_pkg::ADDR_ALARM_SEC: next_alarm_field[0] = reg_wdata;
                rtab_pkg::ADDR_ALARM_MIN: next_alarm_field[1] = reg_wdata;
                rtab_pkg::ADDR_ALARM_HR: next_alarm_field[2] = reg_wdata;
                rtab_pkg::ADDR_ALARM_DATE: next_alarm_field[3] = reg_wdata;
                rtab_pkg::ADDR_ALARM_MON: next_alarm_field[4] = reg_wdata;
                rtab_pkg::ADDR_ALARM_WDAY: next_alarm_field[5] = reg_wdata;
                rtab_pkg::ADDR_INT_CTRL: next_int_ctrl = reg_wdata;
                rtab_pkg::ADDR_BACKUP_CTRL: next_backup_ctrl = {6'h00, reg_wdata[1:0]};
                rtab_pkg::ADDR_IRQ_CLEAR: next_irq_status = irq_status & ~reg_wdata[1:0];
                rtab_pkg::ADDR_IRQ_ENABLE: next_irq_enable = reg_wdata[1:0];
                default: next_irq_status = irq_status;
            endcase
        end
        // sticky set wins over a clear in the same cycle
        if (alarm_event)
            next_irq_status[rtab_pkg::IRQ_ALARM_BIT] = 1'b1;
        if (gate_change)
            next_irq_status[rtab_pkg::IRQ_GATE_BIT] = 1'b1;
        next_irq = |(next_irq_status & next_irq_enable);
    end

    // read data is zero outside the cycle after a read, so no stale value lingers
    always_comb
    begin
        next_reg_rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                rtab_pkg::ADDR_ALARM_SEC: next_reg_rdata = alarm_field[0];
                rtab_pkg::ADDR_ALARM_MIN: next_reg_rdata = alarm_field[1];
                rtab_pkg::ADDR_ALARM_HR: next_reg_rdata = alarm_field[2];
                rtab_pkg::ADDR_ALARM_DATE: next_reg_rdata = alarm_field[3];
                rtab_pkg::ADDR_ALARM_MON: next_reg_rdata = alarm_field[4];
                rtab_pkg::ADDR_ALARM_WDAY: next_reg_rdata = alarm_field[5];
                rtab_pkg::ADDR_INT_CTRL: next_reg_rdata = int_ctrl;
                rtab_pkg::ADDR_BACKUP_CTRL: next_reg_rdata = backup_ctrl;
                rtab_pkg::ADDR_IRQ_STATUS: next_reg_rdata = {5'h00, alarm0_flag, irq_status};
                rtab_pkg::ADDR_IRQ_ENABLE: next_reg_rdata = {6'h00, irq_enable};
                rtab_pkg::ADDR_GATE_STATUS:
                    next_reg_rdata = {2'h0, s_bat_above_reset, s_above_backup,
                        s_above_trip, s_above_reset, on_backup, bus_enable};
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    // every output leaves from a flop, so the pins never carry decode glitches
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < rtab_pkg::NUM_FIELDS; i++)
                alarm_field[i] <= rtab_pkg::RST_FIELD;
            int_ctrl <= rtab_pkg::RST_INT_CTRL;
            backup_ctrl <= rtab_pkg::RST_BACKUP_CTRL;
            irq_status <= 2'h0;
            irq_enable <= rtab_pkg::RST_IRQ_ENABLE[1:0];
            reg_rdata <= 8'h00;
            irq <= 1'b0;
            bus_enable <= 1'b0;
            on_backup <= 1'b0;
            functions_enable <= 1'b1;
            match_prev <= 1'b0;
            alarm0_flag <= 1'b0;
            pulse_cnt <= 8'h00;
            alarm_irq_n <= 1'b1;
        end
        else
        begin
            for (int i = 0; i < rtab_pkg::NUM_FIELDS; i++)
                alarm_field[i] <= next_alarm_field[i];
            int_ctrl <= next_int_ctrl;
            backup_ctrl <= next_backup_ctrl;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            reg_rdata <= next_reg_rdata;
            irq <= next_irq;
            bus_enable <= next_bus_enable;
            on_backup <= next_on_backup;
            functions_enable <= next_functions_enable;
            match_prev <= next_match_prev;
            alarm0_flag <= next_alarm0_flag;
            pulse_cnt <= next_pulse_cnt;
            alarm_irq_n <= next_alarm_irq_n;
        end
    end
endmodule
`default_nettype wire

// ---- bench/rtab_top_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtab_top_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    // supply and bus
    input wire logic vdd_above_reset,
    input wire logic vdd_above_backup,
    input wire logic backup_above_reset,
    input wire logic bus_busy,
    input wire logic time_update,
    // outputs
    input wire logic bus_enable,
    input wire logic on_backup,
    input wire logic functions_enable,
    input wire logic alarm0_flag,
    input wire logic alarm_irq_n
);
    // shadow mode bits; age hides the settling after a mode write
    logic battery_switch_select, serial_bus_in_backup_select, pulsed;
    logic [2:0] age;
    wire logic ok = (age == 3'h7);
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {serial_bus_in_backup_select, battery_switch_select} <= rtab_pkg::RST_BACKUP_CTRL[1:0];
            pulsed <= 1'b0;
            age <= 3'h0;
        end
        else if (reg_wr && reg_addr == rtab_pkg::ADDR_BACKUP_CTRL)
        begin
            {serial_bus_in_backup_select, battery_switch_select} <= reg_wdata[1:0];
            age <= 3'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == rtab_pkg::ADDR_INT_CTRL)
                pulsed <= reg_wdata[7];
            if (!ok)
                age <= age + 3'h1;
        end
    end
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    property p_cut;
        !vdd_above_reset [*4] |-> !bus_enable;
    endproperty
    a_cut: assert property (p_cut) else $error("bus on below reset");
    property p_std;
        (ok && !battery_switch_select && vdd_above_reset && !bus_busy) [*5] |-> bus_enable;
    endproperty
    a_std: assert property (p_std) else $error("standard gate");
    property p_bat;
        (ok && battery_switch_select && !serial_bus_in_backup_select && !backup_above_reset && !bus_busy) [*5] |-> !bus_enable;
    endproperty
    a_bat: assert property (p_bat) else $error("legacy gate");
    property p_max_lo;
        (ok && battery_switch_select && serial_bus_in_backup_select && !vdd_above_backup && !bus_busy) [*5] |-> !bus_enable;
    endproperty
    a_max_lo: assert property (p_max_lo) else $error("max gate low");
    property p_max_hi;
        (ok && battery_switch_select && serial_bus_in_backup_select && vdd_above_reset && vdd_above_backup && !bus_busy) [*5]
            |-> bus_enable;
    endproperty
    a_max_hi: assert property (p_max_hi) else $error("max gate high");
    property p_hold;
        $past(bus_busy) |-> !$rose(bus_enable);
    endproperty
    a_hold: assert property (p_hold) else $error("gate rose in transfer");
    property p_cause;
        $rose(alarm0_flag) |-> $past(time_update);
    endproperty
    a_cause: assert property (p_cause) else $error("flag without update");
    property p_pulse;
        pulsed && $fell(alarm_irq_n) |-> ##24 !alarm_irq_n ##1 alarm_irq_n;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse width");
    property p_single;
        !pulsed && !alarm_irq_n && !reg_rd && !$past(reg_rd) |=> !alarm_irq_n;
    endproperty
    a_single: assert property (p_single) else $error("single irq dropped");
    property p_func;
        !functions_enable |-> on_backup;
    endproperty
    a_func: assert property (p_func) else $error("functions off on main");
endmodule
bind rtab_top rtab_top_asserts i_asserts (.*);
`default_nettype wire

// ---- bench/rtab_i2c_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtab_i2c_host (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // frame request
    input wire logic go,
    input wire logic [7:0] len,
    // start to stop activity
    output logic bus_busy
);
    logic [7:0] cnt;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cnt <= 8'h00;
        else if (go)
            cnt <= len;
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end
    // a new go reloads the count, so the host can cut a running frame short
    assign bus_busy = (cnt != 8'h00);
endmodule
`default_nettype wire

// ---- bench/rtab_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtab_top_tb;
    logic sys_clk, rstn, reg_wr, reg_rd, time_update, go, bus_busy;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, len;
    logic vdd_above_reset, vdd_above_trip, vdd_above_backup, backup_above_reset;
    logic [7:0] clk_seconds, clk_minutes, clk_hours, clk_date, clk_month, clk_weekday;
    logic bus_enable, on_backup, functions_enable, alarm0_flag, alarm_irq_n, irq;
    logic [31:0] seed = 32'h4094;
    logic [3:0] c;
    int errors = 0;
    int samples_checked = 0;
    wire logic [7:0] gate_seen = {5'h00, functions_enable, on_backup, bus_enable};
    rtab_top i_dut (.*);
    rtab_i2c_host i_host (.sys_clk, .rstn, .go, .len, .bus_busy);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // c = {bat>reset, vdd>bat, vdd>trip, vdd>reset}; gives {functions, backup, bus}
    function automatic logic [2:0] exp_gate(input logic [1:0] m, input logic [3:0] v);
        logic bk, bus;
        bk = m[0] ? !v[2] : !v[1];
        bus = !m[0] ? v[0] : (m[1] ? v[0] & v[2] : v[0] & v[3]);
        return {!(bk && !m[0]), bk, bus};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask
    task automatic tick(input logic [7:0] s, input logic [7:0] mi, input logic [7:0] h);
        @(posedge sys_clk);
        {clk_seconds, clk_minutes, clk_hours} <= {s, mi, h};
        time_update <= 1'b1;
        @(posedge sys_clk);
        time_update <= 1'b0;
        #1;
    endtask
    task automatic cmp(input logic [3:0] v);
        @(posedge sys_clk);
        {backup_above_reset, vdd_above_backup, vdd_above_trip, vdd_above_reset} <= v;
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #50us;
        errors++;
        end_of_test();
    end
    initial
    begin
        rstn = 1'b0;
        {reg_wr, reg_rd, time_update, go, reg_addr, reg_wdata, len} = 24'h0;
        {vdd_above_reset, vdd_above_trip, vdd_above_backup, backup_above_reset} = 4'hF;
        {clk_seconds, clk_minutes, clk_hours, clk_date, clk_month, clk_weekday} = 48'h0;
        repeat (2) @(posedge sys_clk);
        #1 chk(8'({bus_enable, on_backup, functions_enable, alarm_irq_n, irq}), 8'h06);
        @(posedge sys_clk);
        rstn <= 1'b1;
        rd(rtab_pkg::ADDR_BACKUP_CTRL, 8'hFF, 8'h01);
        rd(4'hF, 8'hFF, 8'h00);
        rd(rtab_pkg::ADDR_IRQ_CLEAR, 8'hFF, 8'h00);
        $display("test reset done");
        for (int m = 0; m < 4; m++)
        begin
            wr(rtab_pkg::ADDR_BACKUP_CTRL, 8'(m));
            for (int k = 0; k < 10; k++)
            begin
                seed = xs(seed);
                c = (k == 0) ? 4'hF : seed[3:0];
                cmp(c);
                repeat (6) @(posedge sys_clk);
                #1 chk(gate_seen, 8'(exp_gate(2'(m), c)));
            end
        end
        $display("test modes done");
        cmp(4'hF);
        repeat (6) @(posedge sys_clk);
        {go, len} <= {1'b1, 8'h28};
        @(posedge sys_clk);
        go <= 1'b0;
        vdd_above_backup <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 chk(8'(bus_enable), 8'h01);
        cmp(4'hE);
        repeat (6) @(posedge sys_clk);
        #1 chk(8'(bus_enable), 8'h00);
        rd(rtab_pkg::ADDR_GATE_STATUS, 8'hFF, 8'h38);
        rd(rtab_pkg::ADDR_IRQ_STATUS, 8'h02, 8'h02);
        repeat (40) @(posedge sys_clk);
        cmp(4'hF);
        $display("test transfer done");
        {clk_date, clk_month, clk_weekday} <= seed[23:0];
        wr(rtab_pkg::ADDR_ALARM_MIN, 8'hB0);
        wr(rtab_pkg::ADDR_ALARM_HR, 8'h91);
        wr(rtab_pkg::ADDR_IRQ_ENABLE, 8'h01);
        tick(8'h00, 8'h30, 8'h11);
        chk(8'({alarm0_flag, alarm_irq_n, irq}), 8'h02);
        tick(8'h59, 8'h29, 8'h11);
        wr(rtab_pkg::ADDR_INT_CTRL, 8'h20);
        tick(8'h00, 8'h30, 8'h11);
        chk(8'({alarm0_flag, alarm_irq_n, irq}), 8'h05);
        tick(8'h01, 8'h30, 8'h11);
        rd(rtab_pkg::ADDR_IRQ_STATUS, 8'h05, 8'h05);
        chk(8'({alarm0_flag, alarm_irq_n}), 8'h01);
        wr(rtab_pkg::ADDR_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1 chk(8'(irq), 8'h00);
        tick(8'h02, 8'h30, 8'h11);
        chk(8'({alarm0_flag, alarm_irq_n}), 8'h01);
        $display("test single done");
        wr(rtab_pkg::ADDR_ALARM_MIN, 8'h00);
        wr(rtab_pkg::ADDR_ALARM_HR, 8'h00);
        wr(rtab_pkg::ADDR_ALARM_SEC, 8'hB0);
        wr(rtab_pkg::ADDR_IRQ_ENABLE, 8'h00);
        wr(rtab_pkg::ADDR_INT_CTRL, 8'hA0);
        for (int r = 0; r < 2; r++)
        begin
            seed = xs(seed);
            tick(8'h29, seed[7:0], seed[15:8]);
            tick(8'h30, seed[15:8], seed[7:0]);
            chk(8'({alarm0_flag, alarm_irq_n, irq}), 8'h04);
            repeat (rtab_pkg::PULSE_CYCLES - 1) @(posedge sys_clk);
            #1 chk(8'(alarm_irq_n), 8'h00);
            @(posedge sys_clk);
            #1 chk(8'(alarm_irq_n), 8'h01);
        end
        wr(rtab_pkg::ADDR_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1 chk(8'(irq), 8'h01);
        wr(rtab_pkg::ADDR_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1 chk(8'(irq), 8'h00);
        $display("test pulsed done");
        end_of_test();
    end
endmodule
`default_nettype wire
